//--- hdl/fault_alert_pin_control.sv
// fault response, amplifier shutdown control, pin pull-ups and alert pin
// assumes synchronous inputs, a plain register port, and a pad that resolves od_pin_s
// How it works
// R1: each fault either latches until cleared or retries after a wait
// R2: retry wait is 1.5 s or 100 ms, chosen by a control bit
// R3: optional high-impedance amplifier output during fault or manual shutdown
// R4: six separate pull-up enables for bit clock, frame sync, data, shutdown, addresses
// R5: alert asserts on any unmasked live interrupt in live mode, or any unmasked latched interrupt in pulse mode
// R6: live mode: alert follows unmasked live interrupts directly
// R7: pulse mode: alert pulses every 4 ms while a latched interrupt remains
// R8: alert is open-drain by default; internal pull-up enabled by a control bit
// R9: each source has its own mask; masked sources never assert alert
// R10: alert is active low; driven low when asserted
`timescale 1ns/100ps
`default_nettype none
module fault_alert_pin_control
   import fault_alert_pkg::*;
(
   input  wire logic                      clk_sys,
   input  wire logic                      sys_rst,
   input  wire fault_alert_pkg::bus_req_s bus_req,
   output logic [7:0]                     rdata,
   input  wire logic [2:0]                fault_in,
   input  wire logic                      shutdown_pin_n,
   output logic                           amp_enable,
   output logic                           amp_hiz,
   output logic [5:0]                     pullup_en,
   output fault_alert_pkg::od_pin_s       alert_pin_n
);
   import fault_alert_pkg::*;

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   typedef struct packed {
      logic [7:0]       ctrl;
      logic [7:0]       mask;
      logic [7:0]       pull;
      logic [7:0]       rdata;
      logic [2:0]       latched;
      fault_e [2:0]     st;
      logic [2:0][CNT_W-1:0] wcnt;
      logic [CNT_W-1:0] pcnt;
      logic             alert;
      logic             hiz;
      logic             en;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic [2:0] live_unmasked;
   logic [2:0] latch_unmasked;
   logic       any_fault;
   logic       manual_sd;
   logic [2:0] clr;

   always_comb begin
      s_d            = s_q;
      manual_sd      = ~shutdown_pin_n;
      live_unmasked  = fault_in & ~s_q.mask[2:0];              // [R9]
      latch_unmasked = s_q.latched & ~s_q.mask[2:0];           // [R9]
      clr            = '0;
      s_d.rdata      = 8'h00;

      // -----------------------------------------------------------
      // register port
      // -----------------------------------------------------------
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            OFS_CTRL:  s_d.ctrl = bus_req.wdata;
            OFS_MASK:  s_d.mask = {5'h00, bus_req.wdata[2:0]};
            OFS_PULL:  s_d.pull = {2'h0, bus_req.wdata[5:0]};
            OFS_CLEAR: clr = bus_req.wdata[2:0];
            default:   ;
         endcase
      end
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            OFS_CTRL: s_d.rdata = s_q.ctrl;
            OFS_MASK: s_d.rdata = s_q.mask;
            OFS_PULL: s_d.rdata = s_q.pull;
            // status: running, alert asserted, live faults, latched faults
            OFS_STAT: s_d.rdata = {s_q.en, s_q.alert, fault_in, s_q.latched};
            default:  s_d.rdata = 8'h00;
         endcase
      end

      // -----------------------------------------------------------
      // per-source fault policy
      // -----------------------------------------------------------
      for (int i = 0; i < NSRC; i++) begin
         // set wins over clear so a fault at clear time survives
         s_d.latched[i] = (s_q.latched[i] & ~clr[i]) | fault_in[i];
         unique case (s_q.st[i])
            ST_RUN: begin
               if (fault_in[i]) begin
                  if (s_q.ctrl[CTRL_RETRY0 + i]) begin               // [R1]
                     s_d.st[i]   = ST_WAIT;
                     s_d.wcnt[i] = s_q.ctrl[CTRL_WSHORT] ? CNT_W'(WAIT_SHORT_CYC - 1)
                                                          : CNT_W'(WAIT_LONG_CYC - 1); // [R2]
                  end else begin
                     s_d.st[i] = ST_LATCH;                            // [R1]
                  end
               end
            end
            ST_WAIT: begin
               // wait restarts while the fault persists
               if (fault_in[i]) begin
                  s_d.wcnt[i] = s_q.ctrl[CTRL_WSHORT] ? CNT_W'(WAIT_SHORT_CYC - 1)
                                                       : CNT_W'(WAIT_LONG_CYC - 1); // [R2]
               end else if (s_q.wcnt[i] == '0) begin
                  s_d.st[i] = ST_RUN;                                 // [R1]
               end else begin
                  s_d.wcnt[i] = s_q.wcnt[i] - CNT_W'(1);
               end
            end
            ST_LATCH: begin
               if (clr[i] && !fault_in[i]) begin
                  s_d.st[i] = ST_RUN;                                 // [R1]
               end
            end
            default: s_d.st[i] = ST_RUN;
         endcase
      end

      any_fault = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         any_fault = any_fault | (s_d.st[i] != ST_RUN);
      end
      s_d.en  = ~any_fault & ~manual_sd;
      s_d.hiz = s_q.ctrl[CTRL_HIZ] & (any_fault | manual_sd);       // [R3]

      // -----------------------------------------------------------
      // alert generation
      // -----------------------------------------------------------
      if (!s_q.ctrl[CTRL_PULSE]) begin
         s_d.alert = |live_unmasked;                                  // [R5] [R6]
         s_d.pcnt  = '0;
      end else if (|latch_unmasked) begin
         // short low pulse at the start of each period
         s_d.alert = (s_q.pcnt < CNT_W'(PULSE_LOW_CYC));              // [R5] [R7]
         s_d.pcnt  = (s_q.pcnt == CNT_W'(PULSE_CYC - 1)) ? '0 : s_q.pcnt + CNT_W'(1); // [R7]
      end else begin
         s_d.alert = 1'b0;
         s_d.pcnt  = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q         <= '0;
         s_q.ctrl    <= CTRL_RST;
         s_q.mask    <= MASK_RST;
         s_q.pull    <= PULL_RST;
         // all-zero state code is ST_RUN, so every source starts running
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   assign rdata               = s_q.rdata;
   assign amp_enable          = s_q.en;
   assign amp_hiz             = s_q.hiz;                              // [R3]
   assign pullup_en           = s_q.pull[5:0];                        // [R4]
   // never drive high: open-drain only, pull-up optional
   assign alert_pin_n = '{out:     1'b0,                              // [R10]
                          oe:      s_q.alert,                         // [R8] [R10]
                          pull_en: s_q.ctrl[CTRL_APULL]};             // [R8]

endmodule : fault_alert_pin_control
`default_nettype wire

//--- hdl/fault_alert_pkg.sv
// package: constants, types for fault response and alert pin control
// assumes a 40 MHz system clock
package fault_alert_pkg;

   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned WAIT_LONG_MS    = 1500;
   localparam int unsigned WAIT_SHORT_MS   = 100;
   localparam int unsigned PULSE_PERIOD_MS = 4;
   localparam int unsigned WAIT_LONG_CYC   = CLK_HZ / 1000 * WAIT_LONG_MS;
   localparam int unsigned WAIT_SHORT_CYC  = CLK_HZ / 1000 * WAIT_SHORT_MS;
   localparam int unsigned PULSE_CYC       = CLK_HZ / 1000 * PULSE_PERIOD_MS;
   localparam int unsigned PULSE_LOW_CYC   = 40;

   // -----------------------------------------------------------
   // fault sources
   // -----------------------------------------------------------
   localparam int unsigned NSRC      = 3;
   localparam int unsigned SRC_OTEMP = 0;
   localparam int unsigned SRC_OCUR  = 1;
   localparam int unsigned SRC_CLKER = 2;

   // -----------------------------------------------------------
   // pull-up enable field positions
   // -----------------------------------------------------------
   localparam int unsigned NPULL       = 6;
   localparam int unsigned PU_BCLK     = 0;
   localparam int unsigned PU_FRAME_SYNC_PIN    = 1;
   localparam int unsigned PU_SDATA    = 2;
   localparam int unsigned PU_SHDN     = 3;
   localparam int unsigned PU_ADDR0    = 4;
   localparam int unsigned PU_ADDR1    = 5;

   // -----------------------------------------------------------
   // register offsets and reset values
   // -----------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_PULL   = 8'h08;
   localparam logic [7:0] OFS_STAT   = 8'h0c;
   localparam logic [7:0] OFS_CLEAR  = 8'h10;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h07;
   localparam logic [7:0] PULL_RST   = 8'h00;

   // ctrl field positions
   localparam int unsigned CTRL_RETRY0  = 0;
   localparam int unsigned CTRL_WSHORT  = 3;
   localparam int unsigned CTRL_HIZ     = 4;
   localparam int unsigned CTRL_PULSE   = 5;
   localparam int unsigned CTRL_APULL   = 6;

   localparam int unsigned CNT_W = 26;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_LATCH = 2'b01,
      ST_WAIT  = 2'b10
   } fault_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;

   typedef struct packed {
      logic       out;
      logic       oe;
      logic       pull_en;
   } od_pin_s;

endpackage : fault_alert_pkg

//--- verification/alert_host_model.sv
// host model: reads the alert pin level
// assumes: board pull-up on the alert net
`timescale 1ns/100ps
`default_nettype none
module alert_host_model (
   input  wire fault_alert_pkg::od_pin_s alert_pin_n,
   output logic                          irq_pending
);
   // released pin goes to the pull-up, never a stale low
   wire logic level = alert_pin_n.oe ? alert_pin_n.out : 1'b1;
   assign irq_pending = ~level;
endmodule : alert_host_model
`default_nettype wire

//--- verification/fault_alert_checker.sv
// checker: port assertions, bound into the block
// assumes: ctrl and mask shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
module fault_alert_checker (
   input wire logic                      clk_sys,
   input wire logic                      sys_rst,
   input wire fault_alert_pkg::bus_req_s bus_req,
   input wire logic [2:0]                fault_in,
   input wire logic                      shutdown_pin_n,
   input wire logic                      amp_enable,
   input wire logic                      amp_hiz,
   input wire logic [5:0]                pullup_en,
   input wire fault_alert_pkg::od_pin_s  alert_pin_n
);
   import fault_alert_pkg::*;
   logic [7:0] ctrl_q;
   logic [2:0] mask_q;
   wire logic  live = |(fault_in & ~mask_q);
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
         mask_q <= MASK_RST[2:0];
      end else if (bus_req.wr) begin
         if (bus_req.addr == OFS_CTRL) ctrl_q <= bus_req.wdata;
         if (bus_req.addr == OFS_MASK) mask_q <= bus_req.wdata[2:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_latch; $rose(fault_in[0]) && !ctrl_q[0]; endsequence
   sequence s_retry; $fell(fault_in[0]) && ctrl_q[0]; endsequence
   sequence s_pulse; ctrl_q[5] && $rose(alert_pin_n.oe); endsequence
   // a clear write legally releases a latched source
   sequence s_no_clear; !(bus_req.wr && bus_req.addr == OFS_CLEAR) [*7]; endsequence
   pin_low_a: assert property (alert_pin_n.out == 1'b0) else $error("alert out high");
   alert_pull_a: assert property (alert_pin_n.pull_en == ctrl_q[CTRL_APULL]) else $error("pull wrong");
   pullup_set_a: assert property (bus_req.wr && bus_req.addr == OFS_PULL
      |=> pullup_en == $past(bus_req.wdata[5:0])) else $error("pullups stale");
   live_track_a: assert property (!ctrl_q[5] |=> alert_pin_n.oe == $past(live)) else $error("alert off");
   hiz_on_a: assert property (ctrl_q[4] && !shutdown_pin_n |=> amp_hiz) else $error("no hiz");
   fault_stop_a: assert property (fault_in != 3'h0 |=> !amp_enable) else $error("amp in fault");
   latch_hold_a: assert property (s_latch ##1 s_no_clear |=> !amp_enable) else $error("latch lost");
   retry_wait_a: assert property (s_retry |-> !amp_enable [*8]) else $error("retry early");
   pulse_len_a: assert property (s_pulse |-> ##39 alert_pin_n.oe ##1 !alert_pin_n.oe) else $error("pulse");
endmodule : fault_alert_checker
bind fault_alert_pin_control fault_alert_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .bus_req(bus_req), .fault_in(fault_in), .shutdown_pin_n(shutdown_pin_n), .amp_enable(amp_enable),
   .amp_hiz(amp_hiz), .pullup_en(pullup_en), .alert_pin_n(alert_pin_n));
`default_nettype wire

//--- verification/fault_alert_pin_control_bench.sv
// bench: random and corner stimulus
// assumes: checker bound in, host model on alert
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module fault_alert_pin_control_bench;
   import fault_alert_pkg::*;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic       sd_n = 1'b1;
   logic [2:0] flt = 3'h0;
   bus_req_s   rq = '0;
   od_pin_s    al;
   logic [7:0] d, m, rdata;
   logic [5:0] pu;
   logic       amp, hiz, irq;
   int         n, fails = 0, num_checks = 0;
   always #12.5 clk_sys = ~clk_sys;
   fault_alert_pin_control dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(rq), .rdata(rdata),
      .fault_in(flt), .shutdown_pin_n(sd_n), .amp_enable(amp), .amp_hiz(hiz), .pullup_en(pu), .alert_pin_n(al));
   alert_host_model host (.alert_pin_n(al), .irq_pending(irq));
   task automatic results;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   task automatic bus(input logic [7:0] a, input logic [7:0] v, input logic w);
      @(posedge clk_sys) rq <= '{a, v, w, !w};
      @(posedge clk_sys) rq <= '{a, v, 1'b0, 1'b0};
      #1 d = rdata;
   endtask : bus
   task automatic drv(input logic [2:0] f, input int k);
      @(posedge clk_sys) flt <= f;
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : drv
   function automatic logic live(input logic [2:0] f, input logic [2:0] mk);
      return |(f & ~mk);
   endfunction : live
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      results();
   end
   initial begin
      void'($urandom(50));
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus(OFS_MASK, 8'h00, 1'b0);
      `CHK("mask", MASK_RST, d)
      `CHK("amp run", 1'b1, amp)
      bus(8'h3c, 8'h00, 1'b0);
      `CHK("unmapped", 8'h00, d)
      m = 8'($urandom_range(63));
      bus(OFS_PULL, m, 1'b1);
      `CHK("pullup", m[5:0], pu)
      for (int i = 0; i < 40; i++) begin
         m = (i == 0) ? 8'h00 : 8'($urandom_range(7));
         bus(OFS_MASK, m, 1'b1);
         drv(3'($urandom), 2);
         `CHK("alert", live(flt, m[2:0]), al.oe)
         `CHK("irq", live(flt, m[2:0]), irq)
      end
      for (int s = 0; s < NSRC; s++) begin
         drv(3'h0, 1);
         bus(OFS_CLEAR, 8'h07, 1'b1);
         drv(3'h1 << s, 0);
         drv(3'h0, 10);
         `CHK("latched amp", 1'b0, amp)
         `CHK("latched hiz", 1'b0, hiz)
         bus(OFS_STAT, 8'h00, 1'b0);
         `CHK("stat", 8'h01 << s, d)
      end
      // release the last latched source so only the manual shutdown acts
      bus(OFS_CLEAR, 8'h07, 1'b1);
      bus(OFS_CTRL, 8'h10, 1'b1);
      @(posedge clk_sys) sd_n <= 1'b0;
      drv(3'h0, 2);
      `CHK("hiz", 1'b1, hiz)
      `CHK("manual off", 1'b0, amp)
      @(posedge clk_sys) sd_n <= 1'b1;
      drv(3'h0, 1);
      `CHK("hiz off", 1'b0, hiz)
      `CHK("amp back", 1'b1, amp)
      bus(OFS_CLEAR, 8'h07, 1'b1);
      bus(OFS_MASK, 8'h00, 1'b1);
      bus(OFS_CTRL, 8'h60, 1'b1);
      drv(3'h2, 0);
      `CHK("alert pull", 1'b1, al.pull_en)
      drv(3'h0, 0);
      n = 0;
      while (al.oe !== 1'b1 && n < 2000) begin #25 n++; end
      n = 0;
      while (al.oe === 1'b1 && n < 100) begin #25 n++; end
      `CHK("pulse", PULSE_LOW_CYC, n)
      bus(OFS_CLEAR, 8'h07, 1'b1);
      bus(OFS_CTRL, 8'h0f, 1'b1);
      drv(3'h1, 0);
      drv(3'h0, 20);
      `CHK("retry", 1'b0, amp)
      // mid-run reset must drop the pending retry wait
      @(posedge clk_sys) sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus(OFS_CTRL, 8'h00, 1'b0);
      `CHK("ctrl rst", CTRL_RST, d)
      `CHK("amp rst", 1'b1, amp)
      `CHK("pull rst", PULL_RST[5:0], pu)
      `CHK("alert rst", 1'b0, al.oe)
      results();
   end
endmodule : fault_alert_pin_control_bench
`default_nettype wire
